/* File: rtl/slt_core.sv */
// Switching logic task: selectors, gates, timers, pins and process data.
module slt_core #(
    parameter int TICK_LEN = slt_pkg::TICK_CYCLES
) (
    input  wire logic                       CLOCK_IN,
    input  wire logic                       RST_N_IN,
    input  wire slt_pkg::slt_req_t          PARAM_REQ_IN,
    output logic [15:0]                     PARAM_RDATA_OUT,
    output logic                            PARAM_RVALID_OUT,
    input  wire slt_pkg::slt_meas_t [3:0]   ZONE_MEAS_IN,
    input  wire logic [31:0]                BEAMS_IN,
    input  wire logic [7:0]                 SYS_STATUS_IN,
    input  wire logic                       LINK_ACTIVE_IN,
    input  wire logic                       MF_IN,
    output logic                            MF_OUT,
    output logic                            MF_OE_OUT,
    output logic                            SW1_OUT,
    output logic                            SW1_OE_OUT,
    output logic                            TEACH_START_OUT,
    output logic [255:0]                    PD_OUT
);
    import slt_pkg::*;

    logic [7:0]  sel_q [2];          // Source masks per selector.
    logic        gate_q [2];         // One selects OR, zero selects AND.
    slt_delay_t  kind_q [2];         // Delay kind per timer.
    logic [15:0] time_q [2];         // Delay in milliseconds per timer.
    logic        inv_q [2];          // Output inverter per path.
    logic        inv_ext_q;          // External input inverter.
    slt_mf_t     mf_q;               // Multifunction pin function.
    logic [7:0]  alarm_msk_q;        // Mask of alarm status bits.
    logic [15:0] zone_q [4];         // Zone comparison settings.
    logic [7:0]  slot_q [PD_SLOTS];  // Content code of each data slot.
    logic [31:0] beams_q;            // Live or held beam states.
    logic [3:0]  zone_res;           // Zone results.
    logic        ext_lvl;            // External input after inverter.
    logic        hold_on;            // Beam hold is in force.
    logic        gate_res [2];       // Gate results.
    logic        t_q [2];            // Timer outputs.
    logic [15:0] cnt_q [2];          // Elapsed milliseconds per timer.
    logic        ql_q [2];           // Final path results.
    logic        mf_in_q;            // Previous multifunction level.
    logic [16:0] div_q;              // Millisecond divider.
    logic        tick;               // One-cycle millisecond enable.
    logic [7:0]  status_byte;        // Outputs and zone results.

    // Compare one zone measurement against its constant.
    function automatic logic zone_cmp(input slt_meas_t m,
                                      input logic [15:0] cfg);
        logic [7:0] v;
        v = m.blocked_beam_count;
        if (cfg[1:0] == 2'h1) begin
            v = m.first_blocked_beam;
        end else if (cfg[1:0] == 2'h2) begin
            v = m.last_blocked_beam;
        end
        case (cfg[4:2])
            OP_EQ:   zone_cmp = (v == cfg[15:8]);
            OP_GE:   zone_cmp = (v >= cfg[15:8]);
            OP_LE:   zone_cmp = (v <= cfg[15:8]);
            OP_NE:   zone_cmp = (v != cfg[15:8]);
            default: zone_cmp = 1'b0;
        endcase
    endfunction : zone_cmp

    // Produce the byte that one slot code asks for.
    function automatic logic [7:0] slot_byte(input logic [7:0] code,
                                             input logic [7:0] sys,
                                             input logic [7:0] st,
                                             input logic [31:0] bm,
                                             input slt_meas_t [3:0] zm);
        case (code[7:4])
            PD_SYS:  slot_byte = sys;
            PD_STAT: slot_byte = st;
            PD_CHAN: slot_byte = bm[code[1:0]*8 +: 8];
            PD_NBB:  slot_byte = zm[code[1:0]].blocked_beam_count;
            PD_FBB:  slot_byte = zm[code[1:0]].first_blocked_beam;
            PD_LBB:  slot_byte = zm[code[1:0]].last_blocked_beam;
            default: slot_byte = 8'h00;
        endcase
    endfunction : slot_byte

    // Zone results; each is one boolean from its own settings.
    always_comb begin
        for (int z = 0; z < 4; z++) begin
            zone_res[z] = zone_cmp(ZONE_MEAS_IN[z], zone_q[z]);
        end
    end

    // The external level only exists while the pin is an input of that kind.
    assign ext_lvl = (mf_q == MF_EXT) && (MF_IN ^ inv_ext_q);
    assign hold_on = (mf_q == MF_HOLD) && MF_IN;
    assign status_byte = {2'b00, zone_res, ql_q[1], ql_q[0]};
    assign tick = (div_q == 17'(TICK_LEN - 1));

    // Parameter writes; each index holds one setting, except IDX_PD_SLOT, whose data also picks the slot.
    always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            for (int p = 0; p < 2; p++) begin
                sel_q[p]  <= RST_BYTE;
                gate_q[p] <= 1'b0;
                kind_q[p] <= DK_DIRECT;
                time_q[p] <= RST_TIME;
                inv_q[p]  <= 1'b0;
            end
            for (int z = 0; z < 4; z++) begin
                zone_q[z] <= RST_TIME;
            end
            for (int s = 0; s < PD_SLOTS; s++) begin
                slot_q[s] <= RST_BYTE;
            end
            inv_ext_q   <= 1'b0;
            mf_q        <= MF_SWITCH;
            alarm_msk_q <= RST_BYTE;
        end else if (PARAM_REQ_IN.wr) begin
            case (PARAM_REQ_IN.idx)
                IDX_PIN_CFG:   mf_q <= slt_mf_t'(PARAM_REQ_IN.wdata[2:0]);
                IDX_SEL_ONE:   sel_q[0] <= PARAM_REQ_IN.wdata[7:0];
                IDX_SEL_TWO:   sel_q[1] <= PARAM_REQ_IN.wdata[7:0];
                IDX_GATE_ONE:  gate_q[0] <= PARAM_REQ_IN.wdata[0];
                IDX_GATE_TWO:  gate_q[1] <= PARAM_REQ_IN.wdata[0];
                IDX_KIND_ONE:  kind_q[0] <=
                    slt_delay_t'(PARAM_REQ_IN.wdata[1:0]);
                IDX_KIND_TWO:  kind_q[1] <=
                    slt_delay_t'(PARAM_REQ_IN.wdata[1:0]);
                IDX_TIME_ONE:  time_q[0] <= PARAM_REQ_IN.wdata;
                IDX_TIME_TWO:  time_q[1] <= PARAM_REQ_IN.wdata;
                IDX_INV_ONE:   inv_q[0] <= PARAM_REQ_IN.wdata[0];
                IDX_INV_TWO:   inv_q[1] <= PARAM_REQ_IN.wdata[0];
                IDX_INV_EXT:   inv_ext_q <= PARAM_REQ_IN.wdata[0];
                IDX_ALARM_MSK: alarm_msk_q <= PARAM_REQ_IN.wdata[7:0];
                IDX_PD_SLOT: begin
                    slot_q[PARAM_REQ_IN.wdata[SLOT_NUM_LSB +: 5]] <=
                        PARAM_REQ_IN.wdata[7:0];
                end
                IDX_ZONE_BASE + 12'h000: zone_q[0] <= PARAM_REQ_IN.wdata;
                IDX_ZONE_BASE + 12'h002: zone_q[1] <= PARAM_REQ_IN.wdata;
                IDX_ZONE_BASE + 12'h004: zone_q[2] <= PARAM_REQ_IN.wdata;
                IDX_ZONE_BASE + 12'h006: zone_q[3] <= PARAM_REQ_IN.wdata;
                default: begin
                    // Unknown indices are ignored.
                end
            endcase
        end
    end

    // Parameter reads answer one cycle later; unknown indices read zero.
    always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            PARAM_RDATA_OUT  <= RST_TIME;
            PARAM_RVALID_OUT <= 1'b0;
        end else begin
            PARAM_RVALID_OUT <= PARAM_REQ_IN.rd;
            if (PARAM_REQ_IN.rd) begin
                case (PARAM_REQ_IN.idx)
                    IDX_PIN_CFG:   PARAM_RDATA_OUT <= {13'h0000, mf_q};
                    IDX_STATUS:    PARAM_RDATA_OUT <= {8'h00, status_byte};
                    IDX_SEL_ONE:   PARAM_RDATA_OUT <= {8'h00, sel_q[0]};
                    IDX_SEL_TWO:   PARAM_RDATA_OUT <= {8'h00, sel_q[1]};
                    IDX_GATE_ONE:  PARAM_RDATA_OUT <= {15'h0000, gate_q[0]};
                    IDX_GATE_TWO:  PARAM_RDATA_OUT <= {15'h0000, gate_q[1]};
                    IDX_KIND_ONE:  PARAM_RDATA_OUT <= {14'h0000, kind_q[0]};
                    IDX_KIND_TWO:  PARAM_RDATA_OUT <= {14'h0000, kind_q[1]};
                    IDX_TIME_ONE:  PARAM_RDATA_OUT <= time_q[0];
                    IDX_TIME_TWO:  PARAM_RDATA_OUT <= time_q[1];
                    IDX_INV_ONE:   PARAM_RDATA_OUT <= {15'h0000, inv_q[0]};
                    IDX_INV_TWO:   PARAM_RDATA_OUT <= {15'h0000, inv_q[1]};
                    IDX_INV_EXT:   PARAM_RDATA_OUT <= {15'h0000, inv_ext_q};
                    IDX_ALARM_MSK: PARAM_RDATA_OUT <= {8'h00, alarm_msk_q};
                    default:       PARAM_RDATA_OUT <= RST_TIME;
                endcase
            end
        end
    end

    // Free-running divider makes the millisecond enable for both timers.
    always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            div_q <= 17'h00000;
        end else begin
            div_q <= tick ? 17'h00000 : div_q + 17'h00001;
        end
    end

    // Two identical paths: gate, timer, inverter.
    for (genvar p = 0; p < 2; p++) begin : g_path
        logic [4:0] src;
        logic       dly;
        assign src = {ext_lvl, zone_res};
        // An empty mask gives a quiet zero instead of an AND of nothing.
        assign gate_res[p] = (sel_q[p][4:0] == 5'h00) ? 1'b0 :
                             gate_q[p] ? |(src & sel_q[p][4:0])
                                       : &(src | ~sel_q[p][4:0]);
        // Which edge of the gate result must wait for the delay.
        assign dly = gate_res[p] ? (kind_q[p] == DK_ON || kind_q[p] == DK_BOTH)
                                 : (kind_q[p] == DK_OFF || kind_q[p] == DK_BOTH);

        // Timer: a delayed change passes only after it held for the set time; others pass at once.
        always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
            if (!RST_N_IN) begin
                t_q[p]   <= 1'b0;
                cnt_q[p] <= RST_TIME;
            end else if (gate_res[p] == t_q[p]) begin
                cnt_q[p] <= RST_TIME;
            end else if (!dly || cnt_q[p] >= time_q[p]) begin
                t_q[p]   <= gate_res[p];
                cnt_q[p] <= RST_TIME;
            end else if (tick) begin
                cnt_q[p] <= cnt_q[p] + 16'h0001;
            end
        end

        // Inverter sits behind the timer and never feeds back into it.
        always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
            if (!RST_N_IN) begin
                ql_q[p] <= 1'b0;
            end else begin
                ql_q[p] <= t_q[p] ^ inv_q[p];
            end
        end
    end

    // Beam states: held ones may only rise while the hold input is high.
    always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            beams_q <= 32'h00000000;
        end else if (hold_on) begin
            beams_q <= beams_q | BEAMS_IN;
        end else begin
            beams_q <= BEAMS_IN;
        end
    end

    // Pins and teach start; the teach pulse marks a rising input edge.
    always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            SW1_OUT         <= 1'b0;
            SW1_OE_OUT      <= 1'b0;
            MF_OUT          <= 1'b0;
            MF_OE_OUT       <= 1'b0;
            mf_in_q         <= 1'b0;
            TEACH_START_OUT <= 1'b0;
        end else begin
            SW1_OUT    <= ql_q[0];
            SW1_OE_OUT <= !LINK_ACTIVE_IN;
            mf_in_q    <= MF_IN;
            TEACH_START_OUT <= (mf_q == MF_TEACH) && MF_IN && !mf_in_q;
            case (mf_q)
                MF_SWITCH: begin
                    MF_OUT    <= ql_q[1];
                    MF_OE_OUT <= 1'b1;
                end
                MF_ALARM: begin
                    MF_OUT    <= |(SYS_STATUS_IN & alarm_msk_q);
                    MF_OE_OUT <= 1'b1;
                end
                default: begin
                    MF_OUT    <= 1'b0;
                    MF_OE_OUT <= 1'b0;
                end
            endcase
        end
    end

    // Process data: every slot picks its own byte each cycle.
    for (genvar s = 0; s < PD_SLOTS; s++) begin : g_slot
        always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
            if (!RST_N_IN) begin
                PD_OUT[s*8 +: 8] <= RST_BYTE;
            end else begin
                PD_OUT[s*8 +: 8] <= slot_byte(slot_q[s], SYS_STATUS_IN,
                    status_byte, beams_q, ZONE_MEAS_IN);
            end
        end
    end

    default clocking @(posedge CLOCK_IN); endclocking
    default disable iff (!RST_N_IN);

    property p_inv;
        ##1 ql_q[0] == ($past(t_q[0]) ^ $past(inv_q[0]));
    endproperty
    a_inv: assert property (p_inv) else $error("path one inversion wrong");

    property p_sw1_link;
        LINK_ACTIVE_IN |=> !SW1_OE_OUT;
    endproperty
    a_sw1_link: assert property (p_sw1_link) else $error("pin driven on link");

    property p_sw1_val;
        ##2 SW1_OUT == $past(t_q[0] ^ inv_q[0], 2);
    endproperty
    a_sw1_val: assert property (p_sw1_val) else $error("output one wrong");

    property p_mf_in;
        (mf_q == MF_EXT || mf_q == MF_HOLD || mf_q == MF_TEACH) |=> !MF_OE_OUT;
    endproperty
    a_mf_in: assert property (p_mf_in) else $error("input pin driven");

    property p_hold;
        hold_on |=> ((beams_q & $past(beams_q)) == $past(beams_q));
    endproperty
    a_hold: assert property (p_hold) else $error("held beam dropped");

    property p_release;
        !hold_on |=> beams_q == $past(BEAMS_IN);
    endproperty
    a_release: assert property (p_release) else $error("beams not live");

    property p_teach;
        (mf_q == MF_TEACH && MF_IN && !mf_in_q) |=> TEACH_START_OUT ##1
            !TEACH_START_OUT;
    endproperty
    a_teach: assert property (p_teach) else $error("teach pulse wrong");

    property p_alarm;
        mf_q == MF_ALARM |=> MF_OUT == |($past(SYS_STATUS_IN) &
            $past(alarm_msk_q));
    endproperty
    a_alarm: assert property (p_alarm) else $error("alarm level wrong");

    property p_on_delay;
        (kind_q[0] == DK_ON && time_q[0] != 16'h0000 && !t_q[0] &&
            gate_res[0] && cnt_q[0] == 16'h0000) |=> !t_q[0];
    endproperty
    a_on_delay: assert property (p_on_delay) else $error("on delay skipped");
endmodule : slt_core

/* File: include/slt_pkg.sv */
// Package of constants and types for the switching logic task block.
package slt_pkg;
    // Parameter indices of the configuration and status objects.
    localparam logic [11:0] IDX_PIN_CFG   = 12'h079;
    localparam logic [11:0] IDX_STATUS    = 12'h1E1;
    localparam logic [11:0] IDX_SEL_ONE   = 12'h439;
    localparam logic [11:0] IDX_SEL_TWO   = 12'h43A;
    localparam logic [11:0] IDX_GATE_ONE  = 12'h43B;
    localparam logic [11:0] IDX_GATE_TWO  = 12'h43C;
    localparam logic [11:0] IDX_KIND_ONE  = 12'h43D;
    localparam logic [11:0] IDX_KIND_TWO  = 12'h43E;
    localparam logic [11:0] IDX_TIME_ONE  = 12'h43F;
    localparam logic [11:0] IDX_TIME_TWO  = 12'h440;
    localparam logic [11:0] IDX_INV_ONE   = 12'h441;
    localparam logic [11:0] IDX_INV_TWO   = 12'h442;
    localparam logic [11:0] IDX_INV_EXT   = 12'h445;
    localparam logic [11:0] IDX_PD_SLOT   = 12'h043;
    localparam logic [11:0] IDX_ZONE_BASE = 12'h160;
    localparam logic [11:0] IDX_ALARM_MSK = 12'h050;
    // Reset values.
    localparam logic [7:0]  RST_BYTE      = 8'h00;
    localparam logic [15:0] RST_TIME      = 16'h0000;
    // Timing: one millisecond tick derived from the 100 MHz clock.
    localparam int          CLK_MHZ       = 100;
    localparam int          TICK_US       = 1000;
    localparam int          TICK_CYCLES   = CLK_MHZ * TICK_US;
    // Field positions.
    localparam int          SEL_EXT_BIT   = 4;
    localparam int          ST_SW_LSB     = 0;
    localparam int          ST_ZONE_LSB   = 2;
    localparam int          SLOT_NUM_LSB  = 8;
    localparam int          PD_SLOTS      = 32;
    // Multifunction pin functions.
    typedef enum logic [2:0] {
        MF_SWITCH = 3'h0, MF_EXT = 3'h1, MF_HOLD = 3'h2,
        MF_TEACH = 3'h3, MF_ALARM = 3'h4
    } slt_mf_t;
    // Delay kinds: two-bit written codes of the timer mode, bit 0 for on and bit 1 for off.
    typedef enum logic [1:0] {
        DK_DIRECT = 2'h0, DK_ON = 2'h1, DK_OFF = 2'h2, DK_BOTH = 2'h3
    } slt_delay_t;
    // Slot content kinds, upper nibble of a slot configuration byte.
    localparam logic [3:0] PD_NONE = 4'h0, PD_SYS = 4'h1, PD_STAT = 4'h2;
    localparam logic [3:0] PD_CHAN = 4'h3, PD_NBB = 4'h4, PD_FBB = 4'h5;
    localparam logic [3:0] PD_LBB  = 4'h6;
    // Zone comparison operators.
    localparam logic [2:0] OP_EQ = 3'h0, OP_GE = 3'h1, OP_LE = 3'h2;
    localparam logic [2:0] OP_NE = 3'h3;
    // Measurements of one zone.
    typedef struct packed {
        logic [7:0] blocked_beam_count;
        logic [7:0] first_blocked_beam;
        logic [7:0] last_blocked_beam;
    } slt_meas_t;
    // Parameter access request.
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] idx;
        logic [15:0] wdata;
    } slt_req_t;
endpackage : slt_pkg

/* File: testbench/slt_master.sv */
// Parameter bus master model that reads and writes the block's objects.
module slt_master
    import slt_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic [15:0] rdata_in,
    input  wire logic        rvalid_in,
    output slt_req_t         req_out
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle bus: no strobe, address and data hold a pattern of no meaning.
    initial begin
        req_out = '{wr: 1'b0, rd: 1'b0, idx: 12'hA5A, wdata: 16'h5A5A};
    end

    // One write, held for one taking edge, then released with inverted lines.
    task automatic put(input logic [11:0] idx, input logic [15:0] data);
        @(posedge clk_in);
        #1 req_out = '{wr: 1'b1, rd: 1'b0, idx: idx, wdata: data};
        @(posedge clk_in);
        #1 req_out = '{wr: 1'b0, rd: 1'b0, idx: ~idx, wdata: ~data};
    endtask : put

    // One read; the answer stands in the cycle after the taking edge.
    task automatic get(input logic [11:0] idx, output logic [15:0] data);
        @(posedge clk_in);
        #1 req_out = '{wr: 1'b0, rd: 1'b1, idx: idx, wdata: 16'h0000};
        @(posedge clk_in);
        #1 req_out = '{wr: 1'b0, rd: 1'b0, idx: ~idx, wdata: 16'hFFFF};
        // A missing answer yields unknown data so that the compare fails.
        data = (rvalid_in === 1'b1) ? rdata_in : 16'hXXXX;
    endtask : get
endmodule : slt_master

/* File: testbench/slt_core_tb.sv */
// Self-checking bench of the switching logic task block.
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin \
    error_cnt++; $display("[FAIL] %0t got %0h exp %0h", $time, got, exp); \
    end end
module slt_core_tb
    import slt_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic              CLOCK_IN = 1'b0;   // System clock.
    logic              RST_N_IN = 1'b0;   // Active low reset.
    slt_req_t          req;               // Parameter request.
    logic [15:0]       rdata;             // Read data.
    logic              rvalid;            // Read data valid.
    slt_meas_t [3:0]   zm    = '0;        // Zone measurements.
    logic [31:0]       beams = '0;        // Live beam states.
    logic [7:0]        sys   = '0;        // Diagnostic status.
    logic              link  = 1'b0;      // Serial link on pin one.
    logic              mf_in = 1'b0;      // Multifunction pin level.
    logic              mf_out, mf_oe, sw1, sw1_oe, teach;
    logic [255:0]      pd;                // Process data word.
    logic [15:0]       rd;                // Last read value.
    logic [11:0]       r;                 // Current table row.
    int                error_cnt  = 0;
    int                n_compared = 0;
    int                c;

    // Rows: select mask[11:7], OR[6], invert[5], zones[4:1], out one[0].
    localparam logic [11:0] ROWS [7] = '{12'h083, 12'h182, 12'h1C5,
        12'h619, 12'h05E, 12'h0A2, 12'h461};

    // Short tick so a millisecond lasts ten cycles.
    slt_core #(.TICK_LEN(10)) dut (.CLOCK_IN(CLOCK_IN), .RST_N_IN(RST_N_IN),
        .PARAM_REQ_IN(req), .PARAM_RDATA_OUT(rdata),
        .PARAM_RVALID_OUT(rvalid), .ZONE_MEAS_IN(zm), .BEAMS_IN(beams),
        .SYS_STATUS_IN(sys), .LINK_ACTIVE_IN(link), .MF_IN(mf_in),
        .MF_OUT(mf_out), .MF_OE_OUT(mf_oe), .SW1_OUT(sw1),
        .SW1_OE_OUT(sw1_oe), .TEACH_START_OUT(teach), .PD_OUT(pd));

    slt_master m (.clk_in(CLOCK_IN), .rdata_in(rdata), .rvalid_in(rvalid),
        .req_out(req));

    // Clock of 100 MHz.
    initial begin
        forever #5 CLOCK_IN = ~CLOCK_IN;
    end

    // Inputs change one nanosecond after the rising edge.
    task automatic tick(input int n);
        repeat (n) @(posedge CLOCK_IN);
        #1;
    endtask : tick

    // Verdict and end of run.
    task automatic close_out();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out

    // Cuts a hang short; the whole run needs well under this span.
    initial begin
        #200000;
        error_cnt++;
        close_out();
    end

    initial begin
        tick(16);
        RST_N_IN = 1'b1;
        `CHK(sw1, 1'b0)
        `CHK(pd, 256'h0)
        m.get(IDX_KIND_ONE, rd);
        `CHK(rd, 16'h0000)
        // Each zone is true when its blocked count reaches one.
        for (int k = 0; k < 4; k++) begin
            m.put(IDX_ZONE_BASE + 12'(2 * k), 16'h0104);
        end
        // Ordinary cases of selector, gate and inverter on path one.
        foreach (ROWS[i]) begin
            r = ROWS[i];
            m.put(IDX_SEL_ONE, {11'h000, r[11:7]});
            m.put(IDX_GATE_ONE, {15'h0000, r[6]});
            m.put(IDX_INV_ONE, {15'h0000, r[5]});
            for (int k = 0; k < 4; k++) begin
                zm[k].blocked_beam_count = r[k + 1] ? 8'h05 : 8'h00;
            end
            tick(5);
            `CHK(sw1, r[0])
            m.get(IDX_STATUS, rd);
            `CHK(rd, {10'h000, r[4:1], 1'b0, r[0]})
            `CHK(mf_out, 1'b0)
        end
        // Path two, inverted, drives the multifunction pin as output two.
        m.put(IDX_SEL_TWO, 16'h0001);
        m.put(IDX_INV_TWO, 16'h0001);
        tick(5);
        `CHK({mf_oe, mf_out}, 2'h3)
        m.get(IDX_STATUS, rd);
        `CHK(rd, 16'h0003)
        m.get(IDX_SEL_TWO, rd);
        `CHK(rd, 16'h0001)
        m.get(12'h7FF, rd);
        `CHK(rd, 16'h0000)
        // Serial link use takes the first output off its pin.
        link = 1'b1;
        tick(5);
        `CHK(sw1_oe, 1'b0)
        link = 1'b0;
        tick(5);
        `CHK(sw1_oe, 1'b1)
        // On delay of 3 ms on zone one, then inverted, then off delay.
        zm = '0;
        m.put(IDX_SEL_ONE, 16'h0001);
        m.put(IDX_INV_ONE, 16'h0000);
        m.put(IDX_TIME_ONE, 16'h0003);
        m.put(IDX_KIND_ONE, 16'h0001);
        tick(5);
        zm[0].blocked_beam_count = 8'h05;
        tick(20);
        `CHK(sw1, 1'b0)
        tick(30);
        `CHK(sw1, 1'b1)
        m.put(IDX_INV_ONE, 16'h0001);
        tick(5);
        `CHK(sw1, 1'b0)
        m.put(IDX_INV_ONE, 16'h0000);
        m.put(IDX_KIND_ONE, 16'h0002);
        tick(5);
        zm[0].blocked_beam_count = 8'h00;
        tick(20);
        `CHK(sw1, 1'b1)
        tick(30);
        `CHK(sw1, 1'b0)
        m.get(IDX_TIME_ONE, rd);
        `CHK(rd, 16'h0003)
        // Pin as external input, plain and inverted.
        m.put(IDX_KIND_ONE, 16'h0000);
        m.put(IDX_PIN_CFG, 16'h0001);
        m.put(IDX_SEL_ONE, 16'h0010);
        mf_in = 1'b1;
        tick(6);
        `CHK(sw1, 1'b1)
        `CHK(mf_oe, 1'b0)
        m.put(IDX_INV_EXT, 16'h0001);
        tick(6);
        `CHK(sw1, 1'b0)
        // Teach: one rising edge gives exactly one start pulse.
        m.put(IDX_PIN_CFG, 16'h0003);
        mf_in = 1'b0;
        tick(3);
        mf_in = 1'b1;
        c = 0;
        repeat (4) begin
            tick(1);
            if (teach === 1'b1) c++;
        end
        `CHK(c, 1)
        // Alarm: only masked status bits reach the pin.
        m.put(IDX_ALARM_MSK, 16'h0001);
        m.put(IDX_PIN_CFG, 16'h0004);
        sys = 8'h02;
        tick(5);
        `CHK(mf_out, 1'b0)
        sys = 8'h03;
        tick(5);
        `CHK({mf_oe, mf_out}, 2'h3)
        // Hold: beams latch while the pin is high and go live after.
        m.put(IDX_PD_SLOT, 16'h0030);
        m.put(IDX_PIN_CFG, 16'h0002);
        mf_in = 1'b1;
        beams = 32'h0000_0001;
        tick(5);
        beams = 32'h0000_0002;
        tick(5);
        `CHK(pd[7:0], 8'h03)
        mf_in = 1'b0;
        tick(5);
        `CHK(pd[7:0], 8'h02)
        // Status and diagnostic bytes in further slots.
        m.put(IDX_PD_SLOT, 16'h0120);
        m.put(IDX_PD_SLOT, 16'h0210);
        tick(5);
        `CHK(pd[15:8], 8'h02)
        `CHK(pd[23:16], 8'h03)
        // A second reset in mid-run clears outputs and settings.
        RST_N_IN = 1'b0;
        tick(2);
        RST_N_IN = 1'b1;
        `CHK(pd, 256'h0)
        m.get(IDX_INV_TWO, rd);
        `CHK(rd, 16'h0000)
        close_out();
    end
endmodule : slt_core_tb
